// file: rtl/pwt_pkg.sv
// pwt_pkg: register map, field positions and constants of the watchdog.
// assumes 8-bit registers, each on one aligned 32-bit Avalon word.
package pwt_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] PWT_IDX_PROCESSOR_MODE_ONE = 16'h0005;
  localparam logic [15:0] PWT_IDX_WATCHDOG_REFRESH   = 16'h000D;
  localparam logic [15:0] PWT_IDX_WATCHDOG_START     = 16'h000E;
  localparam logic [15:0] PWT_IDX_WATCHDOG_CONTROL   = 16'h000F;
  localparam logic [15:0] PWT_IDX_CLOCK_GUARD_MODE   = 16'h001C;
  localparam logic [15:0] PWT_IDX_OPTION_BYTE_TWO    = 16'hFFDB;
  localparam logic [15:0] PWT_IDX_OPTION_BYTE_ONE    = 16'hFFFF;

  localparam int          PWT_ADDR_W = 18;
  localparam int          PWT_CNT_W  = 14;
  localparam int          PWT_PRE_W  = 7;

  // field positions
  localparam int          PWT_BIT_UNDERFLOW_ACTION  = 2;
  localparam int          PWT_BIT_PRESCALER_SELECT  = 7;
  localparam int          PWT_BIT_CLOCK_GUARD       = 7;
  localparam int          PWT_BIT_AUTO_START        = 0;
  localparam int          PWT_BIT_GUARD_AT_RESET    = 7;
  localparam int          PWT_BIT_PERIOD_LO         = 0;
  localparam int          PWT_BIT_WINDOW_LO         = 2;

  // reset values and masks
  localparam logic [7:0]  PWT_RST_PROCESSOR_MODE    = 8'h00;
  localparam logic [7:0]  PWT_PM1_STORED_MASK       = 8'h83;
  localparam logic [7:0]  PWT_RST_CONTROL_LOW       = 8'h3F;
  localparam logic [7:0]  PWT_ERASED_BYTE           = 8'hFF;

  // refresh sequence values
  localparam logic [7:0]  PWT_REFRESH_FIRST         = 8'h00;
  localparam logic [7:0]  PWT_REFRESH_SECOND        = 8'hFF;

  // counter initial values per underflow-period code
  localparam logic [13:0] PWT_INIT_CODE0            = 14'h03FF;
  localparam logic [13:0] PWT_INIT_CODE1            = 14'h0FFF;
  localparam logic [13:0] PWT_INIT_CODE2            = 14'h1FFF;
  localparam logic [13:0] PWT_INIT_CODE3            = 14'h3FFF;

  // prescaler tick masks: divide-by-16, divide-by-128, divide-by-2
  localparam logic [6:0]  PWT_DIV16_MASK            = 7'h0F;
  localparam logic [6:0]  PWT_DIV128_MASK           = 7'h7F;
  localparam logic [6:0]  PWT_DIV2_MASK             = 7'h01;

endpackage : pwt_pkg

// file: rtl/pwt_watchdog.sv
// pwt_watchdog: program watchdog timer with refresh window and clock guard.
// assumes Avalon-MM master on i_mclk, option bytes and mode pins from outside.
//
// Contract
// R01: 14-bit down counter ticks per prescaled source
// R02: cpu clock prescaled, or low-speed oscillator guarded
// R03: auto-start option bit sampled at reset
// R04: any start register write starts counter
// R05: stop/wait halts unless guard mode on
// R06: 00h then FFh to refresh reloads
// R07: reload on reset, refresh, underflow
// R08: software refreshes only while counting
// R09: underflow gives interrupt or reset per select
// R10: action select bit sets on 1, sticky
// R11: guard mode forces action select to one
// R12: software unlocks mode register before writing
// R13: prescaler select: divide-by-16 or divide-by-128
// R14: control low bits show live counter slice
// R15: control bit 6 reads 0, reset 3Fh
// R16: guard bit set by 0 then 1 only
// R17: option bit 7 sets guard at reset
// R18: period field picks counter initial value
// R19: window field picks 25 to 100 percent
// R20: option bytes read at every reset
// R21: software keeps option reserved bits at one
// R22: low-speed cpu clock makes divide-by-2
// R23: refresh outside window acts as underflow
// R24: guard mode switches on low-speed oscillator
// R25: only FFh right after 00h refreshes
// R26: prescaler cleared only by reset
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps

module pwt_watchdog (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // avalon-mm slave
  input  wire logic [17:0] i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  // flash option bytes and chip state
  input  wire logic [7:0]  i_option_byte_one,
  input  wire logic [7:0]  i_option_byte_two,
  input  wire logic        i_stop_wait_mode,
  input  wire logic        i_low_speed_cpu_clock_select,
  input  wire logic        i_low_speed_osc_clk,
  // watchdog events
  output logic             o_wdt_irq,
  output logic             o_wdt_reset,
  output logic             o_low_speed_osc_enable
);

  // input synchronisers
  logic [7:0]  opt1_s1_reg;
  logic [7:0]  opt1_s2_reg;
  logic [7:0]  opt2_s1_reg;
  logic [7:0]  opt2_s2_reg;
  logic [2:0]  pin_s1_reg;
  logic [2:0]  pin_s2_reg;
  logic        osc_prev_reg;

  always_ff @(posedge i_mclk) begin
    opt1_s1_reg  <= i_option_byte_one;
    opt1_s2_reg  <= opt1_s1_reg;
    opt2_s1_reg  <= i_option_byte_two;
    opt2_s2_reg  <= opt2_s1_reg;
    pin_s1_reg   <= {i_low_speed_osc_clk, i_low_speed_cpu_clock_select, i_stop_wait_mode};
    pin_s2_reg   <= pin_s1_reg;
    osc_prev_reg <= pin_s2_reg[2];
  end

  wire stop_wait = pin_s2_reg[0];
  wire low_cpu   = pin_s2_reg[1];
  wire osc_rise  = pin_s2_reg[2] & ~osc_prev_reg;

  // option snapshot, caught while reset is held
  logic [7:0]  opt1_reg;
  logic [7:0]  opt2_reg;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      opt1_reg <= opt1_s2_reg; // R20
      opt2_reg <= opt2_s2_reg; // R20
    end
  end

  // state
  logic        waitreq_reg;
  logic [31:0] readdata_reg;
  logic        boot_reg;
  logic        running_reg;
  logic        guard_reg;
  logic        guard_arm_reg;
  logic        action_reg;
  logic [7:0]  pm1_reg;
  logic        presel_reg;
  logic        refresh_arm_reg;
  logic [13:0] count_reg;
  logic [6:0]  pre_reg;
  logic        irq_reg;
  logic        wrst_reg;

  // bus decode
  wire         req      = i_read | i_write;
  wire         accept   = req & ~waitreq_reg;
  wire         wr_acc   = accept & i_write;
  wire         aligned  = (i_address[1:0] == 2'b00);
  wire [15:0]  idx      = i_address[17:2];
  wire         sel_pm1  = aligned & (idx == pwt_pkg::PWT_IDX_PROCESSOR_MODE_ONE);
  wire         sel_ref  = aligned & (idx == pwt_pkg::PWT_IDX_WATCHDOG_REFRESH);
  wire         sel_st   = aligned & (idx == pwt_pkg::PWT_IDX_WATCHDOG_START);
  wire         sel_ctl  = aligned & (idx == pwt_pkg::PWT_IDX_WATCHDOG_CONTROL);
  wire         sel_grd  = aligned & (idx == pwt_pkg::PWT_IDX_CLOCK_GUARD_MODE);
  wire         sel_opt2 = aligned & (idx == pwt_pkg::PWT_IDX_OPTION_BYTE_TWO);
  wire         sel_opt1 = aligned & (idx == pwt_pkg::PWT_IDX_OPTION_BYTE_ONE);
  wire [7:0]   wbyte    = i_writedata[7:0];

  // option fields
  wire         auto_start_select = opt1_reg[pwt_pkg::PWT_BIT_AUTO_START];
  wire         clock_guard_at_reset = ~opt1_reg[pwt_pkg::PWT_BIT_GUARD_AT_RESET];
  wire [1:0]   period_code = opt2_reg[pwt_pkg::PWT_BIT_PERIOD_LO +: 2];
  wire [1:0]   window_code = opt2_reg[pwt_pkg::PWT_BIT_WINDOW_LO +: 2];

  // initial value and refresh window
  logic [13:0] init_val;
  logic [5:0]  count_slice;
  always_comb begin
    unique case (period_code)
      2'b00: begin
        init_val    = pwt_pkg::PWT_INIT_CODE0; // R18
        count_slice = count_reg[5:0]; // R14
      end
      2'b01: begin
        init_val    = pwt_pkg::PWT_INIT_CODE1; // R18
        count_slice = count_reg[7:2]; // R14
      end
      2'b10: begin
        init_val    = pwt_pkg::PWT_INIT_CODE2; // R18
        count_slice = count_reg[8:3]; // R14
      end
      2'b11: begin
        init_val    = pwt_pkg::PWT_INIT_CODE3; // R18
        count_slice = count_reg[9:4]; // R14
      end
    endcase
  end

  // window is the last quarter(s) of the period before underflow
  wire [14:0]  period_len = {1'b0, init_val} + 15'h0001;
  wire [14:0]  quarter    = period_len >> 2;
  wire [16:0]  win_limit  = 17'(quarter * ({13'h0000, window_code} + 15'h0001)); // R19
  wire         in_window  = ({3'b000, count_reg} < win_limit); // R19

  // refresh sequence
  wire wr_ref      = wr_acc & sel_ref;
  wire ref_pair    = wr_ref & refresh_arm_reg & (wbyte == pwt_pkg::PWT_REFRESH_SECOND); // R25
  wire ref_ok      = ref_pair & running_reg & in_window; // R06
  wire ref_bad     = ref_pair & running_reg & ~in_window; // R23

  // count source
  wire counting    = running_reg & ~boot_reg & (guard_reg | ~stop_wait); // R05
  wire [6:0] pmask = low_cpu ? pwt_pkg::PWT_DIV2_MASK : // R22
                     presel_reg ? pwt_pkg::PWT_DIV128_MASK : pwt_pkg::PWT_DIV16_MASK; // R13
  wire cpu_tick    = ((pre_reg & pmask) == pmask);
  wire tick        = counting & (guard_reg ? osc_rise : cpu_tick); // R02
  wire underflow   = tick & (count_reg == 14'h0000);
  wire fire        = underflow | ref_bad;

  // next values
  wire guard_set   = wr_acc & sel_grd & guard_arm_reg & wbyte[pwt_pkg::PWT_BIT_CLOCK_GUARD];
  wire pm1_wr      = wr_acc & sel_pm1;
  wire action_next = action_reg | guard_set | // R11
                     (pm1_wr & wbyte[pwt_pkg::PWT_BIT_UNDERFLOW_ACTION]); // R10
  wire [13:0] count_next = (ref_ok | fire) ? init_val : // R07
                           tick ? count_reg - 14'h0001 : count_reg; // R01

  // action select lives in its own sticky flop, merged back in on reads
  wire  [7:0] pm1_view = pm1_reg | (8'(action_reg) << pwt_pkg::PWT_BIT_UNDERFLOW_ACTION); // R10
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (sel_pm1) rd_byte = pm1_view;
    if (sel_ctl) rd_byte = {presel_reg, 1'b0, count_slice}; // R15
    if (sel_grd) rd_byte = {guard_reg, 7'h00};
    if (sel_opt2) rd_byte = opt2_reg;
    if (sel_opt1) rd_byte = opt1_reg;
  end

  // bus handshake: one wait cycle, then answer
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      waitreq_reg  <= 1'b1;
      readdata_reg <= 32'h0000_0000;
    end else begin
      waitreq_reg  <= ~(req & waitreq_reg);
      if (req & waitreq_reg & i_read) begin
        readdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // control registers
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      boot_reg        <= 1'b1;
      running_reg     <= 1'b0;
      guard_reg       <= 1'b0;
      guard_arm_reg   <= 1'b0;
      action_reg      <= 1'b0;
      pm1_reg         <= pwt_pkg::PWT_RST_PROCESSOR_MODE;
      presel_reg      <= pwt_pkg::PWT_RST_CONTROL_LOW[7];
      refresh_arm_reg <= 1'b0;
    end else if (boot_reg) begin
      boot_reg    <= 1'b0;
      running_reg <= ~auto_start_select; // R03
      guard_reg   <= clock_guard_at_reset; // R17
      action_reg  <= clock_guard_at_reset; // R11
    end else begin
      if (wr_acc & sel_st) begin
        running_reg <= 1'b1; // R04
      end
      if (guard_set) begin
        guard_reg <= 1'b1; // R16
      end
      if (wr_acc & sel_grd) begin
        guard_arm_reg <= ~wbyte[pwt_pkg::PWT_BIT_CLOCK_GUARD]; // R16
      end
      action_reg <= action_next;
      if (pm1_wr) begin
        pm1_reg <= wbyte & pwt_pkg::PWT_PM1_STORED_MASK;
      end
      if (wr_acc & sel_ctl) begin
        presel_reg <= wbyte[pwt_pkg::PWT_BIT_PRESCALER_SELECT]; // R13
      end
      if (wr_ref) begin
        refresh_arm_reg <= (wbyte == pwt_pkg::PWT_REFRESH_FIRST); // R25
      end
    end
  end

  // counter and prescaler
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      count_reg <= pwt_pkg::PWT_INIT_CODE3;
      pre_reg   <= 7'h00; // R26
    end else begin
      if (boot_reg) begin
        count_reg <= init_val; // R07
      end else begin
        count_reg <= count_next;
      end
      if (counting & ~guard_reg) begin
        pre_reg <= pre_reg + 7'h01;
      end
    end
  end

  // events: one-cycle pulses
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      irq_reg  <= 1'b0;
      wrst_reg <= 1'b0;
    end else begin
      irq_reg  <= fire & ~action_reg & ~guard_reg; // R09
      wrst_reg <= fire & (action_reg | guard_reg); // R09
    end
  end

  assign o_waitrequest          = waitreq_reg;
  assign o_readdata             = readdata_reg;
  assign o_wdt_irq              = irq_reg;
  assign o_wdt_reset            = wrst_reg;
  assign o_low_speed_osc_enable = guard_reg; // R24

  // checks
  bus_answer_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (req && waitreq_reg) |=> !waitreq_reg)
    else $error("bus request not answered in one cycle");

  start_run_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R04
    (wr_acc && sel_st && !boot_reg) |=> running_reg)
    else $error("start write did not start the counter");

  stop_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R05
    (stop_wait && !guard_reg && !boot_reg && !ref_ok && !ref_bad) |=> $stable(count_reg))
    else $error("counter moved in stop or wait mode");

  refresh_reload_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R06
    (ref_ok && !boot_reg) |=> (count_reg == $past(init_val)))
    else $error("accepted refresh did not reload");

  underflow_event_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R09
    (underflow && !boot_reg) |=> (o_wdt_irq != o_wdt_reset) && (count_reg == $past(init_val)))
    else $error("underflow gave no single event or no reload");

  guard_reset_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R09
    guard_reg |-> ##1 !o_wdt_irq)
    else $error("interrupt raised in guard mode");

  action_sticky_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R10
    action_reg |=> action_reg)
    else $error("action select bit cleared");

  guard_forces_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R11
    guard_reg |-> action_reg)
    else $error("guard mode without reset action");

  guard_nofall_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R16
    (guard_reg && !boot_reg) |=> guard_reg)
    else $error("guard bit cleared by software");

  bad_refresh_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R23
    ref_bad |=> (o_wdt_irq || o_wdt_reset))
    else $error("out-of-window refresh raised no event");

  ctl_bit6_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R15
    (!o_waitrequest && $past(i_read && sel_ctl)) |-> (o_readdata[6] == 1'b0))
    else $error("control bit 6 read as one");

  boot_start_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R03
    boot_reg |=> (running_reg == !$past(auto_start_select)))
    else $error("auto-start option not applied at boot");

  guard_boot_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R17
    boot_reg |=> (guard_reg == $past(clock_guard_at_reset)))
    else $error("guard option not applied at boot");

  div2_rate_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R22
    (counting && !guard_reg && low_cpu && !cpu_tick) |=> (cpu_tick || !low_cpu))
    else $error("low-speed cpu clock did not tick every second cycle");

  refresh_cancel_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R25
    (wr_ref && !boot_reg && (wbyte != pwt_pkg::PWT_REFRESH_FIRST)) |=> !refresh_arm_reg)
    else $error("refresh sequence not cancelled");

  refresh_phase_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R26
    (ref_ok && counting && !guard_reg) |=> (pre_reg == 7'($past(pre_reg) + 7'h01)))
    else $error("refresh disturbed the prescaler");

  event_pulse_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R09
    (o_wdt_irq || o_wdt_reset) |=> !(o_wdt_irq || o_wdt_reset))
    else $error("watchdog event longer than one cycle");

endmodule // pwt_watchdog

// file: testbench/pwt_watchdog_tb.sv
// pwt_watchdog_tb: self-checking bench for the program watchdog timer.
// assumes one Avalon answer a cycle after each request, cpu mostly on low-speed clock.
`timescale 1ns/1ps

module pwt_watchdog_tb;
  localparam logic [17:0] A_PM = {pwt_pkg::PWT_IDX_PROCESSOR_MODE_ONE, 2'b00};
  localparam logic [17:0] A_RF = {pwt_pkg::PWT_IDX_WATCHDOG_REFRESH, 2'b00};
  localparam logic [17:0] A_ST = {pwt_pkg::PWT_IDX_WATCHDOG_START, 2'b00};
  localparam logic [17:0] A_C  = {pwt_pkg::PWT_IDX_WATCHDOG_CONTROL, 2'b00};
  localparam logic [17:0] A_CG = {pwt_pkg::PWT_IDX_CLOCK_GUARD_MODE, 2'b00};
  localparam logic [17:0] A_O1 = {pwt_pkg::PWT_IDX_OPTION_BYTE_ONE, 2'b00};
  localparam logic [17:0] A_O2 = {pwt_pkg::PWT_IDX_OPTION_BYTE_TWO, 2'b00};

  logic        i_mclk                       = 1'b0;
  logic        i_rst_n                      = 1'b0;
  logic [17:0] i_address                    = '0;
  logic        i_read                       = 1'b0;
  logic        i_write                      = 1'b0;
  logic [31:0] i_writedata                  = '0;
  logic [7:0]  i_option_byte_one            = 8'hFF;
  logic [7:0]  i_option_byte_two            = 8'hF0;
  logic        i_stop_wait_mode             = 1'b0;
  logic        i_low_speed_cpu_clock_select = 1'b1;
  logic        i_low_speed_osc_clk          = 1'b0;
  logic [31:0] o_readdata;
  logic        o_waitrequest;
  logic        o_wdt_irq;
  logic        o_wdt_reset;
  logic        o_low_speed_osc_enable;
  logic [2:0]  osc_div                      = '0;
  logic [31:0] seed                         = 32'h0000_B0DB;
  logic [15:0] rq[$];
  logic [1:0]  eq[$];
  logic [7:0]  got;
  logic [7:0]  v;
  int          num_errors                   = 0;
  int          n_tests                      = 0;

  pwt_watchdog u_pwt_watchdog (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_option_byte_one(i_option_byte_one),
    .i_option_byte_two(i_option_byte_two), .i_stop_wait_mode(i_stop_wait_mode),
    .i_low_speed_cpu_clock_select(i_low_speed_cpu_clock_select),
    .i_low_speed_osc_clk(i_low_speed_osc_clk), .o_wdt_irq(o_wdt_irq),
    .o_wdt_reset(o_wdt_reset), .o_low_speed_osc_enable(o_low_speed_osc_enable));

  always #5 i_mclk = ~i_mclk;

  // slow oscillator: 8 mclk period, well inside the synchronizer limits
  always @(posedge i_mclk) begin
    osc_div             <= osc_div + 3'h1;
    i_low_speed_osc_clk <= osc_div[2];
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic miss(input logic [31:0] e, input logic [31:0] g);
    num_errors++;
    $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
  endtask

  // masked read compare; an empty queue means a read nobody asked for
  task automatic chk_rd(input logic [31:0] g);
    logic [15:0] n;
    n_tests++;
    n = (rq.size() != 0) ? rq.pop_front() : 16'h0000;
    if ((({24'h0, n[15:8]} ^ g) & {24'hFFFFFF, n[7:0]}) !== 32'h0)
      miss({24'h0, n[15:8]}, g);
  endtask

  task automatic chk_evt(input logic [1:0] g);
    logic [1:0] e;
    n_tests++;
    e = (eq.size() != 0) ? eq.pop_front() : 2'b00;
    if (g !== e)
      miss({30'h0, e}, {30'h0, g});
  endtask

  task automatic chk_lvl(input logic g, input logic e);
    n_tests++;
    if (g !== e)
      miss({31'h0, e}, {31'h0, g});
  endtask

  always @(posedge i_mclk) begin
    if (i_read && o_waitrequest === 1'b0)
      chk_rd(o_readdata);
    if (i_rst_n && (o_wdt_irq !== 1'b0 || o_wdt_reset !== 1'b0))
      chk_evt({o_wdt_reset, o_wdt_irq});
  end

  task automatic bus(input logic rd_n_wr, input logic [17:0] a, input logic [7:0] d,
                     input logic [15:0] note);
    int n;
    @(posedge i_mclk);
    if (rd_n_wr)
      rq.push_back(note);
    i_address   <= a;
    i_read      <= rd_n_wr;
    i_write     <= !rd_n_wr;
    i_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 20);
    got = o_readdata[7:0];
    if (n >= 20) begin
      miss(32'h0, 32'h1);
      tally_and_finish();
    end
    i_read  <= 1'b0;
    i_write <= 1'b0;
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    bus(1'b0, a, d, 16'h0000);
  endtask

  task automatic rd(input logic [17:0] a, input logic [7:0] e, input logic [7:0] m);
    bus(1'b1, a, 8'h00, {e, m});
  endtask

  task automatic wait_evt(input int bound);
    int n;
    n = 0;
    while (eq.size() != 0 && n < bound) begin
      @(posedge i_mclk);
      n++;
    end
    if (eq.size() != 0) begin
      miss({30'h0, eq[0]}, 32'h0);
      tally_and_finish();
    end
  endtask

  // three edges so the option-byte synchronizer and snapshot settle
  task automatic do_reset(input logic [7:0] o1);
    @(posedge i_mclk);
    i_rst_n           <= 1'b0;
    i_option_byte_one <= o1;
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
  endtask

  initial begin
    do_reset(8'hFF);
    rd(A_C, 8'h3F, 8'hFF);
    rd(A_PM, 8'h00, 8'hFF);
    rd(A_RF, 8'h00, 8'hFF);
    rd(A_CG, 8'h00, 8'hFF);
    rd(18'h00100, 8'h00, 8'hFF);
    rd(A_O1, 8'hFF, 8'hFF);
    rd(A_O2, 8'hF0, 8'hFF);
    repeat (50) @(posedge i_mclk);
    rd(A_C, 8'h3F, 8'hFF);
    wr(A_C, 8'h80);
    rd(A_C, 8'hBF, 8'hFF);
    wr(A_C, 8'h00);
    $display("registers and stopped state done");
    wr(A_ST, rnd());
    rd(A_C, 8'h3C, 8'h3C);
    v = rnd();
    if (v == 8'hFF || v == 8'h00)
      v = 8'h5A;
    wr(A_RF, 8'h00);
    wr(A_RF, v);
    wr(A_RF, 8'hFF);
    eq.push_back(2'b01);
    wr(A_RF, 8'h00);
    wr(A_RF, 8'hFF);
    wait_evt(20);
    $display("refresh order and early refresh done");
    i_stop_wait_mode <= 1'b1;
    repeat (6) @(posedge i_mclk);
    rd(A_C, 8'h00, 8'h00);
    v = got;
    repeat (100) @(posedge i_mclk);
    rd(A_C, v, 8'h3F);
    i_stop_wait_mode <= 1'b0;
    $display("stop hold done");
    eq.push_back(2'b01);
    wait_evt(2600);
    // about 850 ticks: count near 173, inside the last quarter
    repeat (1700) @(posedge i_mclk);
    wr(A_RF, 8'h00);
    wr(A_RF, 8'hFF);
    rd(A_C, 8'h3C, 8'h3C);
    $display("underflow and window refresh done");
    wr(A_PM, 8'h04);
    wr(A_PM, 8'h00);
    rd(A_PM, 8'h04, 8'hFF);
    eq.push_back(2'b10);
    wait_evt(2600);
    $display("reset action done");
    do_reset(8'hFF);
    wr(A_CG, 8'h00);
    wr(A_CG, 8'h80);
    wr(A_CG, 8'h00);
    rd(A_CG, 8'h80, 8'hFF);
    rd(A_PM, 8'h04, 8'hFF);
    chk_lvl(o_low_speed_osc_enable, 1'b1);
    i_stop_wait_mode <= 1'b1;
    wr(A_ST, rnd());
    eq.push_back(2'b10);
    wait_evt(9000);
    i_stop_wait_mode <= 1'b0;
    $display("guard mode done");
    do_reset(8'h7E);
    rd(A_CG, 8'h80, 8'hFF);
    rd(A_PM, 8'h04, 8'hFF);
    chk_lvl(o_low_speed_osc_enable, 1'b1);
    eq.push_back(2'b10);
    wait_evt(9000);
    $display("guard and auto start at reset done");
    // cpu clock source, divide-by-16, half-period refresh window
    i_low_speed_cpu_clock_select <= 1'b0;
    i_option_byte_two            <= 8'hF4;
    do_reset(8'hFE);
    rd(A_O2, 8'hF4, 8'hFF);
    // about 562 ticks: count near 1CDh, inside half but not quarter window
    repeat (9000) @(posedge i_mclk);
    wr(A_RF, 8'h00);
    wr(A_RF, 8'hFF);
    repeat (16000) @(posedge i_mclk);
    eq.push_back(2'b01);
    wait_evt(1000);
    $display("divide-by-16 and half window done");
    tally_and_finish();
  end
endmodule // pwt_watchdog_tb
